// [rtl/pie_defs.svh]
`ifndef PIE_DEFS_SVH
`define PIE_DEFS_SVH
// Behaviour
// R1: each source picks vectored or transfer service
// R2: vectored service branches to source vector
// R3: transfer steals exactly one cycle
// R4: move byte/word, bump source or destination
// R5: counter decrements unless continuous mode
// R6: counter zero gives vectored interrupt instead
// R7: eight channels, own pointers and counter
// R8: per-source request, enable and level
// R9: sixteen priority levels
// R10: preempt only by strictly higher level
// R11: every source has own vector
// R12: fast inputs: rising, falling or both
// R13: software trap vectors to given number
// R14: vector address is four times trap
// R15: last four sources use traps 40h-43h; code gives sources 52-55 traps 44h-47h
// R16: response between 200 and 480 ns
// R17: event sets flag, acceptance clears it
// R18: enabled, above cpu level, lowest trap wins; code takes the highest level first, lowest trap only on a tie

`define PIE_NSRC        56
`define PIE_NCH         8
`define PIE_NFAST       8
`define PIE_FAST_BASE   8
`define PIE_TRAP_BASE   7'h10

// register map, byte addresses
`define PIE_SRC_END     12'h0e0
`define PIE_CH_BASE     12'h100
`define PIE_CH_END      12'h180
`define PIE_EDGE_ADDR   12'h200
`define PIE_STAT_ADDR   12'h204

// source control fields
`define PIE_F_EN        6
`define PIE_F_REQ       7
`define PIE_F_XFER      11
// channel control fields
`define PIE_F_WORD      8
`define PIE_F_INCDST    9
`define PIE_F_CONT      10

`define PIE_RST_WORD    32'h0000_0000
`define PIE_RESP_OKAY   2'h0
`define PIE_RESP_SLVERR 2'h2

// timing
`define PIE_CLK_MHZ     200
`define PIE_LAT_MIN_NS  200
`define PIE_LAT_MAX_NS  480
`define PIE_LAT_MIN_CYC ((`PIE_LAT_MIN_NS * `PIE_CLK_MHZ + 999) / 1000)
`define PIE_LAT_MAX_CYC ((`PIE_LAT_MAX_NS * `PIE_CLK_MHZ) / 1000)
`endif

// [rtl/pie_pkg.sv]
package pie_pkg;
  typedef enum logic [1:0] {
    PIE_IDLE = 2'b00,
    PIE_WAIT = 2'b01,
    PIE_VECT = 2'b11,
    PIE_XFER = 2'b10
  } pie_state_e;

  typedef logic [3:0] pie_lvl_t;
  typedef logic [5:0] pie_idx_t;

  typedef struct packed {
    logic [7:0]  cnt;
    logic        word;
    logic        inc_dst;
    logic        cont;
    logic [15:0] src;
    logic [15:0] dst;
  } pie_chan_s;
endpackage

// [rtl/pie_arb_if.sv]
`include "pie_defs.svh"
interface pie_arb_if;
  logic [`PIE_NSRC-1:0] req;
  logic [`PIE_NSRC-1:0] en;
  pie_pkg::pie_lvl_t    lvl [`PIE_NSRC];
  pie_pkg::pie_lvl_t    cpu_lvl;
  logic                 win_v;
  pie_pkg::pie_idx_t    win_idx;
  pie_pkg::pie_lvl_t    win_lvl;

  modport top (output req, en, lvl, cpu_lvl, input win_v, win_idx, win_lvl);
  modport arb (input req, en, lvl, cpu_lvl, output win_v, win_idx, win_lvl);
endinterface

// [rtl/pie_arbiter.sv]
`include "pie_defs.svh"
module pie_arbiter (
  // request view and winner
  pie_arb_if.arb bus
);
  always_comb begin
    bus.win_v   = 1'b0;
    bus.win_idx = '0;
    bus.win_lvl = '0;
    // ascending scan with strict compare keeps the lowest trap on a tie
    for (int i = 0; i < `PIE_NSRC; i++) begin
      if (bus.req[i] && bus.en[i] && bus.lvl[i] > bus.cpu_lvl) begin // see R18 see R10
        if (!bus.win_v || bus.lvl[i] > bus.win_lvl) begin // see R9
          bus.win_v   = 1'b1;
          bus.win_idx = pie_pkg::pie_idx_t'(i);
          bus.win_lvl = bus.lvl[i];
        end
      end
    end
  end
endmodule

// [rtl/pie_ctrl.sv]
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`include "pie_defs.svh"
module pie_ctrl (
  // clock, reset, freeze
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // request sources
  input  wire logic [55:0] src_event,
  input  wire logic [7:0]  fast_pin,
  input  wire logic        sw_trap_stb,
  input  wire logic [6:0]  sw_trap_num,
  // cpu core
  input  wire logic [3:0]  cpu_ilvl,
  output logic             irq_req,
  output logic [6:0]       irq_trap,
  output logic [8:0]       irq_vector,
  output logic [3:0]       irq_ilvl,
  input  wire logic        irq_ack,
  output logic             xfer_stb,
  output logic             xfer_word,
  output logic [15:0]      xfer_src,
  output logic [15:0]      xfer_dst
);
  localparam int NS = `PIE_NSRC;

  // source control state
  logic [NS-1:0]        req_r;
  logic [NS-1:0]        en_r;
  logic [NS-1:0]        xfer_en_r;
  pie_pkg::pie_lvl_t    lvl_r [NS];
  logic [2:0]           chsel_r [NS];
  pie_pkg::pie_chan_s   ch_r [`PIE_NCH];
  logic [15:0]          edge_sel_r;
  logic [7:0]           pin_q_r;
  // service sequencing
  pie_pkg::pie_state_e  st_r;
  pie_pkg::pie_idx_t    cur_idx_r;
  pie_pkg::pie_lvl_t    cur_lvl_r;
  logic [6:0]           cur_trap_r;
  logic                 cur_sw_r;
  logic                 sw_pend_r;
  logic [6:0]           sw_num_r;
  logic [7:0]           lat_cnt_r;
  logic                 irq_req_r;
  logic [6:0]           irq_trap_r;
  logic [8:0]           irq_vector_r;
  logic [3:0]           irq_ilvl_r;
  logic                 xfer_stb_r;
  logic                 xfer_word_r;
  logic [15:0]          xfer_src_r;
  logic [15:0]          xfer_dst_r;
  // bus slave
  logic                 awready_r;
  logic                 aw_have_r;
  logic [11:0]          awaddr_r;
  logic                 wready_r;
  logic                 w_have_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 arready_r;
  logic                 rvalid_r;
  logic [31:0]          rdata_r;
  logic [1:0]           rresp_r;

  logic                 wr_fire;
  logic [31:0]          wr_word;
  logic                 wr_src;
  logic                 wr_ch;
  pie_pkg::pie_idx_t    wr_idx;
  logic [2:0]           wr_chn;
  logic [7:0]           fast_ev;
  logic [NS-1:0]        ev;
  logic [NS-1:0]        hw_clr;
  pie_pkg::pie_chan_s   cur_chan;
  logic                 lat_done;
  logic                 pec_go;
  logic                 last_xfer;

  pie_arb_if arb ();

  pie_arbiter u_arb (
    .bus (arb.arb)
  );

  assign arb.req     = req_r;
  assign arb.en      = en_r;
  assign arb.lvl     = lvl_r;
  assign arb.cpu_lvl = cpu_ilvl;

  assign awready    = awready_r;
  assign wready     = wready_r;
  assign bvalid     = bvalid_r;
  assign bresp      = bresp_r;
  assign arready    = arready_r;
  assign rvalid     = rvalid_r;
  assign rdata      = rdata_r;
  assign rresp      = rresp_r;
  assign irq_req    = irq_req_r;
  assign irq_trap   = irq_trap_r;
  assign irq_vector = irq_vector_r;
  assign irq_ilvl   = irq_ilvl_r;
  assign xfer_stb   = xfer_stb_r;
  assign xfer_word  = xfer_word_r;
  assign xfer_src   = xfer_src_r;
  assign xfer_dst   = xfer_dst_r;

  function automatic logic addr_hit(input logic [11:0] a);
    return (a < `PIE_SRC_END) ||
           (a >= `PIE_CH_BASE && a < `PIE_CH_END && a[3:2] != 2'h3) ||
           (a[11:2] == `PIE_EDGE_ADDR >> 2) || (a[11:2] == `PIE_STAT_ADDR >> 2);
  endfunction

  function automatic logic [31:0] reg_val(input logic [11:0] a);
    logic [31:0]        v;
    pie_pkg::pie_chan_s c;
    pie_pkg::pie_idx_t  i;
    v = `PIE_RST_WORD;
    c = ch_r[a[6:4]];
    i = a[7:2];
    if (a < `PIE_SRC_END) begin
      v[3:0]          = lvl_r[i];
      v[`PIE_F_EN]    = en_r[i];
      v[`PIE_F_REQ]   = req_r[i];
      v[10:8]         = chsel_r[i];
      v[`PIE_F_XFER]  = xfer_en_r[i];
    end else if (a >= `PIE_CH_BASE && a < `PIE_CH_END) begin
      case (a[3:2])
        2'h0: v = {21'h0, c.cont, c.inc_dst, c.word, c.cnt};
        2'h1: v = {16'h0, c.src};
        2'h2: v = {16'h0, c.dst};
        default: v = `PIE_RST_WORD;
      endcase
    end else if (a[11:2] == `PIE_EDGE_ADDR >> 2) begin
      v = {16'h0, edge_sel_r};
    end else if (a[11:2] == `PIE_STAT_ADDR >> 2) begin
      v = {17'h0, cur_trap_r, 2'h0, st_r, cur_lvl_r};
    end
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        v[8*b +: 8] = d[8*b +: 8];
      end
    end
    return v;
  endfunction

  function automatic logic [6:0] trap_of(input pie_pkg::pie_idx_t i);
    return `PIE_TRAP_BASE + {1'b0, i}; // see R11 see R14 see R15
  endfunction

  // write path: both halves must be held before the register is touched
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  always_comb begin
    wr_word = merge(reg_val(awaddr_r), wdata_r, wstrb_r);
  end
  assign wr_src  = wr_fire && awaddr_r < `PIE_SRC_END;
  assign wr_ch   = wr_fire && awaddr_r >= `PIE_CH_BASE && awaddr_r < `PIE_CH_END;
  assign wr_idx  = awaddr_r[7:2];
  assign wr_chn  = awaddr_r[6:4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_have_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (ce) begin
      if (awvalid && awready_r) begin
        awready_r <= 1'b0;
        aw_have_r <= 1'b1;
        awaddr_r  <= awaddr;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end else if (!aw_have_r) begin
        awready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_have_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (ce) begin
      if (wvalid && wready_r) begin
        wready_r <= 1'b0;
        w_have_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end else if (!w_have_r) begin
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `PIE_RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= addr_hit(awaddr_r) ? `PIE_RESP_OKAY : `PIE_RESP_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= `PIE_RST_WORD;
      rresp_r   <= `PIE_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= reg_val(araddr);
        rresp_r   <= addr_hit(araddr) ? `PIE_RESP_OKAY : `PIE_RESP_SLVERR;
      end else if (rvalid_r && rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end else if (!rvalid_r) begin
        arready_r <= 1'b1;
      end
    end
  end

  // fast pins feed sources 8..15; a disabled pin (00) raises nothing
  always_comb begin
    fast_ev = '0;
    for (int j = 0; j < `PIE_NFAST; j++) begin
      fast_ev[j] = (edge_sel_r[2*j] & fast_pin[j] & ~pin_q_r[j]) |
                   (edge_sel_r[2*j+1] & ~fast_pin[j] & pin_q_r[j]); // see R12
    end
    ev = src_event | (NS'(fast_ev) << `PIE_FAST_BASE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q_r    <= '0;
      edge_sel_r <= '0;
    end else if (ce) begin
      pin_q_r <= fast_pin;
      if (wr_fire && awaddr_r[11:2] == `PIE_EDGE_ADDR >> 2) begin
        edge_sel_r <= wr_word[15:0];
      end
    end
  end

  assign cur_chan  = ch_r[chsel_r[cur_idx_r]];
  assign lat_done  = lat_cnt_r == 8'(`PIE_LAT_MIN_CYC - 1);
  assign last_xfer = !cur_chan.cont && cur_chan.cnt == 8'h01;
  assign pec_go    = st_r == pie_pkg::PIE_WAIT && lat_done && !cur_sw_r &&
                     req_r[cur_idx_r] && xfer_en_r[cur_idx_r] &&
                     (cur_chan.cnt != 8'h00 || cur_chan.cont); // see R1 see R6

  // the last transfer leaves the flag up so the source then takes its vector
  always_comb begin
    hw_clr = '0;
    if (pec_go && !last_xfer) begin
      hw_clr[cur_idx_r] = 1'b1; // see R6
    end
    if (st_r == pie_pkg::PIE_VECT && irq_req_r && irq_ack && !cur_sw_r) begin
      hw_clr[cur_idx_r] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_r <= '0;
    end else if (ce) begin
      for (int i = 0; i < NS; i++) begin
        if (ev[i]) begin
          req_r[i] <= 1'b1; // see R17
        end else if (hw_clr[i]) begin
          req_r[i] <= 1'b0; // see R17
        end else if (wr_src && wr_idx == pie_pkg::pie_idx_t'(i)) begin
          req_r[i] <= wr_word[`PIE_F_REQ];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r      <= '0;
      xfer_en_r <= '0;
      for (int i = 0; i < NS; i++) begin
        lvl_r[i]   <= '0;
        chsel_r[i] <= '0;
      end
    end else if (ce && wr_src) begin
      en_r[wr_idx]      <= wr_word[`PIE_F_EN]; // see R8
      xfer_en_r[wr_idx] <= wr_word[`PIE_F_XFER]; // see R1
      lvl_r[wr_idx]     <= wr_word[3:0]; // see R9
      chsel_r[wr_idx]   <= wr_word[10:8];
    end
  end

  // a transfer in the same cycle as a software write to its channel wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < `PIE_NCH; c++) begin
        ch_r[c] <= '0;
      end
    end else if (ce) begin
      if (wr_ch) begin
        case (awaddr_r[3:2])
          2'h0: begin
            ch_r[wr_chn].cnt     <= wr_word[7:0];
            ch_r[wr_chn].word    <= wr_word[`PIE_F_WORD];
            ch_r[wr_chn].inc_dst <= wr_word[`PIE_F_INCDST];
            ch_r[wr_chn].cont    <= wr_word[`PIE_F_CONT];
          end
          2'h1: ch_r[wr_chn].src <= wr_word[15:0];
          2'h2: ch_r[wr_chn].dst <= wr_word[15:0];
          default: ;
        endcase
      end
      if (pec_go) begin
        if (!cur_chan.cont) begin
          ch_r[chsel_r[cur_idx_r]].cnt <= cur_chan.cnt - 8'h01; // see R5 see R7
        end
        if (cur_chan.inc_dst) begin
          ch_r[chsel_r[cur_idx_r]].dst <= cur_chan.dst + (cur_chan.word ? 16'h2 : 16'h1); // see R4
        end else begin
          ch_r[chsel_r[cur_idx_r]].src <= cur_chan.src + (cur_chan.word ? 16'h2 : 16'h1); // see R4
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_pend_r <= 1'b0;
      sw_num_r  <= '0;
    end else if (ce) begin
      if (sw_trap_stb) begin
        sw_pend_r <= 1'b1; // see R13
        sw_num_r  <= sw_trap_num;
      end else if (st_r == pie_pkg::PIE_IDLE) begin
        sw_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r         <= pie_pkg::PIE_IDLE;
      cur_idx_r    <= '0;
      cur_lvl_r    <= '0;
      cur_trap_r   <= '0;
      cur_sw_r     <= 1'b0;
      lat_cnt_r    <= '0;
      irq_req_r    <= 1'b0;
      irq_trap_r   <= '0;
      irq_vector_r <= '0;
      irq_ilvl_r   <= '0;
      xfer_stb_r   <= 1'b0;
      xfer_word_r  <= 1'b0;
      xfer_src_r   <= '0;
      xfer_dst_r   <= '0;
    end else if (ce) begin
      case (st_r)
        pie_pkg::PIE_IDLE: begin
          lat_cnt_r <= '0;
          if (sw_pend_r) begin
            cur_sw_r   <= 1'b1; // see R13
            cur_trap_r <= sw_num_r;
            cur_lvl_r  <= cpu_ilvl;
            st_r       <= pie_pkg::PIE_WAIT;
          end else if (arb.win_v) begin
            cur_sw_r   <= 1'b0;
            cur_idx_r  <= arb.win_idx;
            cur_lvl_r  <= arb.win_lvl;
            cur_trap_r <= trap_of(arb.win_idx);
            st_r       <= pie_pkg::PIE_WAIT;
          end
        end
        pie_pkg::PIE_WAIT: begin
          // hold-off keeps the response inside its window for fast acks
          lat_cnt_r <= lat_cnt_r + 8'h01; // see R16
          if (lat_done) begin
            if (pec_go) begin
              xfer_stb_r  <= 1'b1; // see R3
              xfer_word_r <= cur_chan.word; // see R4
              xfer_src_r  <= cur_chan.src;
              xfer_dst_r  <= cur_chan.dst;
              st_r        <= pie_pkg::PIE_XFER;
            end else if (cur_sw_r || req_r[cur_idx_r]) begin
              irq_req_r    <= 1'b1; // see R2
              irq_trap_r   <= cur_trap_r;
              irq_vector_r <= {cur_trap_r, 2'b00}; // see R14
              irq_ilvl_r   <= cur_lvl_r;
              st_r         <= pie_pkg::PIE_VECT;
            end else begin
              st_r <= pie_pkg::PIE_IDLE;
            end
          end
        end
        pie_pkg::PIE_VECT: begin
          if (irq_ack) begin
            irq_req_r <= 1'b0;
            st_r      <= pie_pkg::PIE_IDLE;
          end
        end
        pie_pkg::PIE_XFER: begin
          xfer_stb_r <= 1'b0; // see R3
          st_r       <= pie_pkg::PIE_IDLE;
        end
        default: st_r <= pie_pkg::PIE_IDLE;
      endcase
    end
  end
endmodule

// [tb/pie_ctrl_sva.sv]
module pie_ctrl_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic [11:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  // cpu side
  input wire logic [3:0]  cpu_ilvl,
  input wire logic        irq_req,
  input wire logic [6:0]  irq_trap,
  input wire logic [8:0]  irq_vector,
  input wire logic [3:0]  irq_ilvl,
  input wire logic        irq_ack,
  input wire logic        xfer_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] gap_r;

  // quiet cycles since the last service output, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn || irq_req || xfer_stb) begin
      gap_r <= 8'h00;
    end else if (gap_r != 8'hff) begin
      gap_r <= gap_r + 8'h01;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence

  a_wr_answer: assert property (s_wr_take |-> ##2 bvalid)
    else $error("write response not on time");
  a_rd_answer: assert property (s_rd_take |=> rvalid)
    else $error("read response not on time");
  a_rd_unmapped: assert property (s_rd_take ##0 (araddr == 12'h10c) |=> rresp == 2'h2)
    else $error("unmapped read not refused");
  a_irq_hold: assert property (irq_req && !irq_ack |=> irq_req && $stable(irq_trap))
    else $error("vectored request dropped early");
  a_ack_clears: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request stands after acceptance");
  a_vec_times4: assert property (irq_req |-> irq_vector == {irq_trap, 2'b00})
    else $error("vector is not four times trap");
  a_xfer_single: assert property (xfer_stb |=> !xfer_stb)
    else $error("transfer took more than one cycle");
  a_one_service: assert property (!(irq_req && xfer_stb))
    else $error("vectored and transfer service together");
  a_lvl_above: assert property ($rose(irq_req) |-> irq_ilvl >= cpu_ilvl)
    else $error("service below cpu level");
  a_lat_floor: assert property ($rose(irq_req) || xfer_stb |-> gap_r >= 8'h28)
    else $error("service answered too soon");
endmodule

// [tb/pie_cpu_model.sv]
module pie_cpu_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // vectored request handshake
  input  wire logic       irq_req,
  input  wire logic [3:0] ack_dly,
  output logic            irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;

  // a slow core leaves the request standing; the ack lasts one cycle only
  always_ff @(posedge aclk) begin
    if (!aresetn || irq_ack || !irq_req) begin
      irq_ack <= 1'b0;
      wait_r  <= 4'h0;
    end else if (wait_r >= ack_dly) begin
      irq_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// [tb/prioritized_interrupt_and_event_transfer_tb.sv]
module prioritized_interrupt_and_event_transfer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] FP_PIN = {2'd0, 2'd2, 2'd2, 2'd1, 2'd1, 2'd0};
  localparam logic [5:0]  FP_LVL = 6'b001011;
  localparam logic [5:0]  FP_HIT = 6'b011101;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf, cpu_ilvl = 4'h0, ack_dly = 4'h0, irq_ilvl;
  logic [55:0] src_event = 56'h0;
  logic [7:0]  fast_pin = 8'h00;
  logic        sw_trap_stb = 1'b0;
  logic [6:0]  sw_trap_num = 7'h00, irq_trap;
  logic        awready, wready, bvalid, arready, rvalid, irq_req, irq_ack, xfer_stb, xfer_word;
  logic [1:0]  bresp, rresp;
  logic [8:0]  irq_vector;
  logic [15:0] xfer_src, xfer_dst;
  logic [39:0] svc_q[$];
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  int          err_count = 0, num_checks = 0, seed = 93991;

  always #2.5 aclk = ~aclk;

  pie_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .src_event(src_event), .fast_pin(fast_pin), .sw_trap_stb(sw_trap_stb),
    .sw_trap_num(sw_trap_num), .cpu_ilvl(cpu_ilvl), .irq_req(irq_req), .irq_trap(irq_trap),
    .irq_vector(irq_vector), .irq_ilvl(irq_ilvl), .irq_ack(irq_ack), .xfer_stb(xfer_stb),
    .xfer_word(xfer_word), .xfer_src(xfer_src), .xfer_dst(xfer_dst));

  pie_cpu_model cpu_u (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req), .ack_dly(ack_dly),
    .irq_ack(irq_ack));

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
    num_checks++;
    if (s !== e) begin
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      err_count++;
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 400) begin
      $display("CHECK FAILED wait exp done got timeout");
      err_count++;
      end_of_test();
    end
  endtask

  function automatic logic [39:0] ei(input logic [6:0] t, input logic [3:0] l);
    return {1'b0, t, 7'h00, t, 2'b00, 12'h000, l};
  endfunction

  function automatic logic [39:0] ex(input logic w, input logic [15:0] s, input logic [15:0] d);
    return {1'b1, 6'h00, w, s, d};
  endfunction

  // the monitor owns all comparisons of results against the noted expectations
  always @(posedge aclk) begin
    if (aresetn && ((irq_req && irq_ack) || xfer_stb))
      chk("service", svc_q.size() ? svc_q.pop_front() : 40'hx, xfer_stb ?
        ex(xfer_word, xfer_src, xfer_dst) : {1'b0, irq_trap, 7'h00, irq_vector, 12'h0, irq_ilvl});
    if (aresetn && rvalid && rready)
      chk("read", rd_q.size() ? {6'h00, rd_q.pop_front()} : 40'hx, {6'h00, rresp, rdata});
    if (aresetn && bvalid && bready)
      chk("bresp", wr_q.size() ? {38'h0, wr_q.pop_front()} : 40'hx, {38'h0, bresp});
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    wr_q.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    tmo(n);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    rd_q.push_back({er, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    tmo(n);
    rready <= 1'b0;
  endtask

  task automatic cfg(input logic [5:0] i, input logic [3:0] l, input logic x, input logic [2:0] c);
    wr({4'h0, i, 2'b00}, {20'h0, x, c, 1'b0, 1'b1, 2'b00, l}, 2'h0);
  endtask

  task automatic pulse(input logic [55:0] m);
    @(posedge aclk);
    src_event <= m;
    @(posedge aclk);
    src_event <= 56'h0;
  endtask

  task automatic drain;
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (svc_q.size() == 0) break;
    end
    tmo(n);
  endtask

  initial begin
    logic [3:0] lv;
    logic [6:0] num;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(12'h000, 32'h0, 2'h0);
    rd(12'h10c, 32'h0, 2'h2);
    wr(12'h300, 32'h1, 2'h2);
    for (int j = 48; j < 52; j++) begin
      lv = 4'($random(seed)) | 4'h1;
      ack_dly <= 4'($random(seed));
      cfg(6'(j), lv, 1'b0, 3'h0);
      svc_q.push_back(ei(7'(j + 16), lv));
      pulse(56'h1 << j);
      drain();
      rd({4'h0, 6'(j), 2'b00}, {25'h0, 1'b1, 2'b00, lv}, 2'h0);
    end
    // all blocked at cpu level 9, then released together
    cpu_ilvl <= 4'h9;
    for (int k = 2; k < 6; k++) cfg(6'(k), (k < 4) ? 4'h7 : 4'h9, 1'b0, 3'h0);
    pulse(56'h3c);
    repeat (60) @(posedge aclk);
    svc_q.push_back(ei(7'h14, 4'h9));
    svc_q.push_back(ei(7'h15, 4'h9));
    svc_q.push_back(ei(7'h12, 4'h7));
    svc_q.push_back(ei(7'h13, 4'h7));
    cpu_ilvl <= 4'h0;
    drain();
    // word transfers on channel 2 until the count runs out
    cfg(6'd0, 4'h4, 1'b1, 3'h2);
    wr(12'h120, 32'h0000_0302, 2'h0);
    wr(12'h124, 32'h0000_1000, 2'h0);
    wr(12'h128, 32'h0000_2000, 2'h0);
    svc_q.push_back(ex(1'b1, 16'h1000, 16'h2000));
    pulse(56'h1);
    drain();
    svc_q.push_back(ex(1'b1, 16'h1000, 16'h2002));
    svc_q.push_back(ei(7'h10, 4'h4));
    pulse(56'h1);
    drain();
    rd(12'h120, 32'h0000_0300, 2'h0);
    // continuous byte transfers on channel 3 stepping the source pointer
    cfg(6'd1, 4'h4, 1'b1, 3'h3);
    wr(12'h130, 32'h0000_0400, 2'h0);
    wr(12'h134, 32'h0000_0010, 2'h0);
    wr(12'h138, 32'h0000_0020, 2'h0);
    for (int k = 0; k < 2; k++) begin
      svc_q.push_back(ex(1'b0, 16'h0010 + 16'(k), 16'h0020));
      pulse(56'h2);
      drain();
    end
    rd(12'h130, 32'h0000_0400, 2'h0);
    rd(12'h134, 32'h0000_0012, 2'h0);
    // fast pins: 0 rising, 1 falling, 2 both
    wr(12'h200, 32'h0000_0039, 2'h0);
    for (int k = 8; k < 11; k++) cfg(6'(k), 4'h2, 1'b0, 3'h0);
    for (int k = 0; k < 6; k++) begin
      if (FP_HIT[k]) svc_q.push_back(ei(7'h18 + 7'(FP_PIN[2*k +: 2]), 4'h2));
      @(posedge aclk);
      fast_pin[FP_PIN[2*k +: 2]] <= FP_LVL[k];
      repeat (50) @(posedge aclk);
      drain();
    end
    for (int k = 0; k < 4; k++) begin
      num = 7'($random(seed));
      cpu_ilvl <= 4'(k);
      @(posedge aclk);
      sw_trap_stb <= 1'b1;
      sw_trap_num <= num;
      @(posedge aclk);
      sw_trap_stb <= 1'b0;
      // frozen longer than the hold-off: a service during the freeze finds no note
      ce <= 1'b0;
      repeat (50) @(posedge aclk);
      svc_q.push_back(ei(num, 4'(k)));
      ce <= 1'b1;
      drain();
    end
    end_of_test();
  end
endmodule

bind pie_ctrl pie_ctrl_sva sva_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rresp(rresp), .rvalid(rvalid), .cpu_ilvl(cpu_ilvl),
  .irq_req(irq_req), .irq_trap(irq_trap), .irq_vector(irq_vector), .irq_ilvl(irq_ilvl),
  .irq_ack(irq_ack), .xfer_stb(xfer_stb));
